// ### hw/efc_frame_checker.sv
// Frame checker top: source select, counters, snapshots, interrupt and registers
`timescale 1ns/100ps
`default_nettype none
module efc_frame_checker
    import efc_pkg::*;
#(
    parameter int LEN_W = 16,
    parameter int CNT_W = 16
) (
    input wire logic sys_clk_in,
    input wire logic rst_in,
    input wire logic rx_stb_in,
    input wire logic rx_dv_in,
    input wire logic rx_er_in,
    input wire logic [3:0] rx_nib_in,
    input wire logic tx_stb_in,
    input wire logic tx_en_in,
    input wire logic tx_er_in,
    input wire logic [3:0] tx_nib_in,
    input wire logic [15:0] reg_addr_in,
    input wire logic [15:0] reg_wdata_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    output logic [15:0] reg_rdata_out,
    output logic reg_rvalid_out,
    output logic irq_out
);

    // ****************************************************************
    // Declarations
    // ****************************************************************
    logic checker_on_r;
    logic checker_irq_on_r;
    logic checker_source_select_r;
    logic checker_generator_irq_mask_r;
    logic checker_generator_irq_pending_r;
    logic [15:0] max_frame_length_r;

    logic [31:0] frame_cnt_r;
    logic [CNT_W-1:0] crc_err_cnt_r;
    logic [CNT_W-1:0] sym_cnt_r;
    logic [CNT_W-1:0] osz_cnt_r;
    logic [CNT_W-1:0] usz_cnt_r;

    logic [31:0] frame_snap_r;
    logic [CNT_W-1:0] sym_snap_r;
    logic [CNT_W-1:0] osz_snap_r;
    logic [CNT_W-1:0] usz_snap_r;

    logic sel_stb;
    logic sel_dv;
    logic sel_er;
    logic [3:0] sel_nib;
    logic m_done;
    logic m_crc_bad;
    logic m_sym_bad;
    logic [LEN_W-1:0] m_len;

    logic frame_ok;
    logic rx_error;
    logic is_oversized;
    logic is_undersized;
    logic rd_err_cnt;
    logic rd_status;

    // Register strobe decode
    function automatic logic efc_hit(input logic stb, input logic [15:0] addr, input logic [15:0] target);
        return stb && (addr == target);
    endfunction

    // ****************************************************************
    // Source selection
    // ****************************************************************
    // Transmit side is the path a far-loopback test checks at the MAC side
    always_comb begin
        if (checker_source_select_r) begin // RULE3 RULE10
            sel_stb = tx_stb_in;
            sel_dv = tx_en_in;
            sel_er = tx_er_in;
            sel_nib = tx_nib_in;
        end else begin
            sel_stb = rx_stb_in;
            sel_dv = rx_dv_in;
            sel_er = rx_er_in;
            sel_nib = rx_nib_in;
        end
    end

    efc_frame_meter #(
        .LEN_W(LEN_W)
    ) u_meter (
        .sys_clk_in(sys_clk_in),
        .rst_in(rst_in),
        .stb_in(sel_stb),
        .dv_in(sel_dv),
        .er_in(sel_er),
        .nib_in(sel_nib),
        .done_out(m_done),
        .crc_bad_out(m_crc_bad),
        .sym_bad_out(m_sym_bad),
        .len_out(m_len)
    );

    // ****************************************************************
    // Frame classification
    // ****************************************************************
    assign frame_ok = m_done && checker_on_r; // RULE1
    assign rx_error = frame_ok && (m_crc_bad || m_sym_bad); // RULE4
    assign is_oversized = m_len > max_frame_length_r; // RULE6
    assign is_undersized = m_len < EFC_MIN_FRAME_BYTES; // RULE12
    assign rd_err_cnt = efc_hit(reg_rd_in, reg_addr_in, EFC_ADDR_RECEIVE_ERROR_COUNTER);
    assign rd_status = efc_hit(reg_rd_in, reg_addr_in, EFC_ADDR_IRQ_STATUS);

    // ****************************************************************
    // Control registers
    // ****************************************************************
    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            checker_on_r <= EFC_RST_CHECKER_ON; // RULE1
            checker_irq_on_r <= EFC_RST_IRQ_ON; // RULE4
            checker_source_select_r <= EFC_RST_SOURCE_SEL; // RULE3
            checker_generator_irq_mask_r <= EFC_RST_IRQ_MASK;
            max_frame_length_r <= EFC_RST_MAX_LEN; // RULE6
        end else if (reg_wr_in) begin
            if (reg_addr_in == EFC_ADDR_CHECKER_ON) begin
                checker_on_r <= reg_wdata_in[0];
            end
            if (reg_addr_in == EFC_ADDR_IRQ_ON) begin
                checker_irq_on_r <= reg_wdata_in[0];
            end
            if (reg_addr_in == EFC_ADDR_SOURCE_SEL) begin
                checker_source_select_r <= reg_wdata_in[0];
            end
            if (reg_addr_in == EFC_ADDR_IRQ_MASK) begin
                checker_generator_irq_mask_r <= reg_wdata_in[EFC_IRQ_BIT];
            end
            if (reg_addr_in == EFC_ADDR_MAX_LEN) begin
                max_frame_length_r <= reg_wdata_in;
            end
        end
    end

    // ****************************************************************
    // Live counters
    // ****************************************************************
    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            frame_cnt_r <= '0; // RULE13
            crc_err_cnt_r <= '0;
            sym_cnt_r <= '0;
            osz_cnt_r <= '0;
            usz_cnt_r <= '0;
        end else if (frame_ok) begin // RULE1
            frame_cnt_r <= frame_cnt_r + 32'h00000001; // RULE2 RULE13
            if (m_crc_bad) begin
                crc_err_cnt_r <= crc_err_cnt_r + 1'b1; // RULE2
            end
            if (m_sym_bad) begin
                sym_cnt_r <= sym_cnt_r + 1'b1; // RULE2
            end
            if (is_oversized) begin
                osz_cnt_r <= osz_cnt_r + 1'b1; // RULE6
            end
            if (is_undersized) begin
                usz_cnt_r <= usz_cnt_r + 1'b1; // RULE12
            end
        end
    end

    // ****************************************************************
    // Snapshots taken when the receive error counter is read
    // ****************************************************************
    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            frame_snap_r <= '0;
            sym_snap_r <= '0;
            osz_snap_r <= '0;
            usz_snap_r <= '0;
        end else if (rd_err_cnt) begin
            frame_snap_r <= frame_cnt_r; // RULE8
            sym_snap_r <= sym_cnt_r;
            osz_snap_r <= osz_cnt_r;
            usz_snap_r <= usz_cnt_r; // RULE12
        end
    end

    // ****************************************************************
    // Interrupt
    // ****************************************************************
    // A new error in the cycle the status is read stays pending
    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            checker_generator_irq_pending_r <= 1'b0;
            irq_out <= 1'b0;
        end else begin
            if (rx_error && checker_irq_on_r) begin
                checker_generator_irq_pending_r <= 1'b1; // RULE4
            end else if (rd_status) begin
                checker_generator_irq_pending_r <= 1'b0;
            end
            irq_out <= checker_generator_irq_pending_r && checker_generator_irq_mask_r; // RULE5
        end
    end

    // ****************************************************************
    // Read port
    // ****************************************************************
    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            reg_rdata_out <= '0;
            reg_rvalid_out <= 1'b0;
        end else begin
            reg_rvalid_out <= reg_rd_in;
            if (reg_rd_in) begin
                reg_rdata_out <= '0;
                unique case (reg_addr_in)
                    EFC_ADDR_RECEIVE_ERROR_COUNTER: reg_rdata_out <= 16'(crc_err_cnt_r);
                    EFC_ADDR_IRQ_MASK: reg_rdata_out[EFC_IRQ_BIT] <= checker_generator_irq_mask_r;
                    EFC_ADDR_IRQ_STATUS: reg_rdata_out[EFC_IRQ_BIT] <= checker_generator_irq_pending_r; // RULE5
                    EFC_ADDR_CHECKER_ON: reg_rdata_out[0] <= checker_on_r;
                    EFC_ADDR_IRQ_ON: reg_rdata_out[0] <= checker_irq_on_r;
                    EFC_ADDR_SOURCE_SEL: reg_rdata_out[0] <= checker_source_select_r;
                    EFC_ADDR_MAX_LEN: reg_rdata_out <= max_frame_length_r;
                    EFC_ADDR_CNT_UPPER: reg_rdata_out <= frame_snap_r[31:16]; // RULE9
                    EFC_ADDR_CNT_LOWER: reg_rdata_out <= frame_snap_r[15:0]; // RULE11
                    EFC_ADDR_SYM_CNT: reg_rdata_out <= 16'(sym_snap_r);
                    EFC_ADDR_OSZ_CNT: reg_rdata_out <= 16'(osz_snap_r);
                    EFC_ADDR_USZ_CNT: reg_rdata_out <= 16'(usz_snap_r);
                    default: reg_rdata_out <= '0;
                endcase
            end
        end
    end

    // ****************************************************************
    // Assertions
    // ****************************************************************
    sequence s_snap_taken;
        rd_err_cnt ##1 1'b1;
    endsequence

    sequence s_err_seen;
        rx_error && checker_irq_on_r ##1 checker_generator_irq_pending_r;
    endsequence

    property p_gate_off;
        @(posedge sys_clk_in) disable iff (rst_in)
        (!checker_on_r && m_done) |=> $stable(frame_cnt_r) && $stable(osz_cnt_r);
    endproperty
    a_gate_off: assert property (p_gate_off) else $error("frame counted while checker off"); // RULE1

    property p_frame_inc;
        @(posedge sys_clk_in) disable iff (rst_in)
        frame_ok |=> frame_cnt_r == $past(frame_cnt_r) + 32'h00000001;
    endproperty
    a_frame_inc: assert property (p_frame_inc) else $error("frame count did not advance"); // RULE2

    property p_frame_idle;
        @(posedge sys_clk_in) disable iff (rst_in)
        !frame_ok |=> $stable(frame_cnt_r);
    endproperty
    a_frame_idle: assert property (p_frame_idle) else $error("frame count moved without frame"); // RULE13

    property p_irq_raise;
        @(posedge sys_clk_in) disable iff (rst_in)
        (rx_error && checker_irq_on_r && checker_generator_irq_mask_r) |-> s_err_seen ##1 irq_out;
    endproperty
    a_irq_raise: assert property (p_irq_raise) else $error("receive error did not raise interrupt"); // RULE4

    property p_irq_masked;
        @(posedge sys_clk_in) disable iff (rst_in)
        !checker_generator_irq_mask_r |=> !irq_out;
    endproperty
    a_irq_masked: assert property (p_irq_masked) else $error("interrupt pin active while masked"); // RULE5

    property p_osz;
        @(posedge sys_clk_in) disable iff (rst_in)
        (frame_ok && m_len > max_frame_length_r) |=> osz_cnt_r == $past(osz_cnt_r) + 1'b1;
    endproperty
    a_osz: assert property (p_osz) else $error("oversized frame not counted"); // RULE6

    property p_usz;
        @(posedge sys_clk_in) disable iff (rst_in)
        (frame_ok && m_len >= EFC_MIN_FRAME_BYTES) |=> $stable(usz_cnt_r);
    endproperty
    a_usz: assert property (p_usz) else $error("full-size frame counted undersized"); // RULE12

    property p_snap;
        @(posedge sys_clk_in) disable iff (rst_in)
        s_snap_taken |-> frame_snap_r == $past(frame_cnt_r);
    endproperty
    a_snap: assert property (p_snap) else $error("snapshot does not match live count"); // RULE8

    property p_upper;
        @(posedge sys_clk_in) disable iff (rst_in)
        efc_hit(reg_rd_in, reg_addr_in, EFC_ADDR_CNT_UPPER) |=>
            reg_rvalid_out && reg_rdata_out == $past(frame_snap_r[31:16]);
    endproperty
    a_upper: assert property (p_upper) else $error("upper count read wrong"); // RULE9

    property p_lower;
        @(posedge sys_clk_in) disable iff (rst_in)
        efc_hit(reg_rd_in, reg_addr_in, EFC_ADDR_CNT_LOWER) |=>
            reg_rvalid_out && reg_rdata_out == $past(frame_snap_r[15:0]);
    endproperty
    a_lower: assert property (p_lower) else $error("lower count read wrong"); // RULE11

    property p_source;
        @(posedge sys_clk_in) disable iff (rst_in)
        checker_source_select_r |-> sel_stb == tx_stb_in && sel_dv == tx_en_in;
    endproperty
    a_source: assert property (p_source) else $error("transmit path not selected"); // RULE3

endmodule
`default_nettype wire

// ### hw/efc_pkg.sv
// Constants, register map and field layout of the Ethernet frame checker
// ****************************************************************
// Functional notes
// (RULE1) Frame analysis and counting run only while checker_on is set; resets to one.
// (RULE2) Count received frames, CRC error frames and frames with other errors.
// (RULE3) Source select one checks MAC transmit frames; zero (reset) checks remote frames.
// (RULE4) Receive error with checker_irq_on set raises the checker interrupt; enable resets one.
// (RULE5) Interrupt pin needs the mask bit too; pending state readable in status.
// (RULE6) Sixteen-bit max_frame_length, reset 0x5F2; longer frames count as oversized.
// (RULE7) Measured frame length excludes preamble and start frame delimiter.
// (RULE8) Live 32-bit frame count is snapshotted whenever receive_error_counter is read.
// (RULE9) frame_count_upper reads upper sixteen bits of the snapshot, not live count.
// (RULE10) Software may use far loopback with transmit-side checking as a test setup.
// (RULE11) frame_count_lower reads lower sixteen bits of the snapshot.
// (RULE12) Frames under 64 bytes count as undersized; snapshotted with the rest.
// (RULE13) Live frame counter wraps after its maximum and clears on reset.
// ****************************************************************
package efc_pkg;

    // ****************************************************************
    // Register offsets
    // ****************************************************************
    localparam logic [15:0] EFC_ADDR_RECEIVE_ERROR_COUNTER = 16'h0014;
    localparam logic [15:0] EFC_ADDR_IRQ_MASK = 16'h0018;
    localparam logic [15:0] EFC_ADDR_IRQ_STATUS = 16'h0019;
    localparam logic [15:0] EFC_ADDR_CHECKER_ON = 16'h9403;
    localparam logic [15:0] EFC_ADDR_IRQ_ON = 16'h9406;
    localparam logic [15:0] EFC_ADDR_SOURCE_SEL = 16'h9407;
    localparam logic [15:0] EFC_ADDR_MAX_LEN = 16'h9408;
    localparam logic [15:0] EFC_ADDR_CNT_UPPER = 16'h940A;
    localparam logic [15:0] EFC_ADDR_CNT_LOWER = 16'h940B;
    localparam logic [15:0] EFC_ADDR_SYM_CNT = 16'h940E;
    localparam logic [15:0] EFC_ADDR_OSZ_CNT = 16'h940F;
    localparam logic [15:0] EFC_ADDR_USZ_CNT = 16'h9410;

    // ****************************************************************
    // Field positions and reset values
    // ****************************************************************
    localparam int EFC_IRQ_BIT = 1;
    localparam logic EFC_RST_CHECKER_ON = 1'h1;
    localparam logic EFC_RST_IRQ_ON = 1'h1;
    localparam logic EFC_RST_SOURCE_SEL = 1'h0;
    localparam logic EFC_RST_IRQ_MASK = 1'h0;
    localparam logic [15:0] EFC_RST_MAX_LEN = 16'h05F2;

    // ****************************************************************
    // Frame format
    // ****************************************************************
    localparam logic [15:0] EFC_MIN_FRAME_BYTES = 16'h0040;
    localparam logic [3:0] EFC_SFD_NIBBLE = 4'hD;
    localparam logic [31:0] EFC_CRC_INIT = 32'hFFFFFFFF;
    localparam logic [31:0] EFC_CRC_POLY = 32'hEDB88320;
    localparam logic [31:0] EFC_CRC_RESIDUE = 32'hDEBB20E3;

endpackage

// ### hw/efc_frame_meter.sv
// Nibble-stream frame parser: SFD search, length, CRC and symbol error check
`timescale 1ns/100ps
`default_nettype none
module efc_frame_meter
    import efc_pkg::*;
#(
    parameter int LEN_W = 16
) (
    input wire logic sys_clk_in,
    input wire logic rst_in,
    input wire logic stb_in,
    input wire logic dv_in,
    input wire logic er_in,
    input wire logic [3:0] nib_in,
    output logic done_out,
    output logic crc_bad_out,
    output logic sym_bad_out,
    output logic [LEN_W-1:0] len_out
);

    typedef enum logic [1:0] {EFC_IDLE, EFC_PRE, EFC_BODY} efc_meter_state_t;

    efc_meter_state_t state_r;
    logic [LEN_W:0] nib_cnt_r;
    logic [31:0] crc_r;
    logic sym_r;

    // Reflected CRC-32, one nibble, least significant bit first
    function automatic logic [31:0] efc_crc_nib(input logic [31:0] crc, input logic [3:0] d);
        logic [31:0] c;
        c = crc;
        for (int i = 0; i < 4; i++) begin
            c = c[0] ^ d[i] ? ((c >> 1) ^ EFC_CRC_POLY) : (c >> 1);
        end
        return c;
    endfunction

    // ****************************************************************
    // Frame state
    // ****************************************************************
    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            state_r <= EFC_IDLE;
        end else if (stb_in) begin
            unique case (state_r)
                EFC_IDLE: if (dv_in) begin
                    state_r <= EFC_PRE;
                end
                EFC_PRE: if (!dv_in) begin
                    state_r <= EFC_IDLE;
                end else if (nib_in == EFC_SFD_NIBBLE) begin
                    state_r <= EFC_BODY;
                end
                EFC_BODY: if (!dv_in) begin
                    state_r <= EFC_IDLE;
                end
            endcase
        end
    end

    // ****************************************************************
    // Body accumulation; preamble and SFD are not part of the length
    // ****************************************************************
    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            nib_cnt_r <= '0;
            crc_r <= EFC_CRC_INIT;
            sym_r <= 1'b0;
        end else if (stb_in) begin
            if (state_r != EFC_BODY) begin
                nib_cnt_r <= '0; // RULE7
                crc_r <= EFC_CRC_INIT;
                // An error marked anywhere in the preamble stays with the frame
                sym_r <= dv_in && (er_in || ((state_r == EFC_PRE) && sym_r));
            end else if (dv_in) begin
                if (nib_cnt_r != '1) begin
                    nib_cnt_r <= nib_cnt_r + 1'b1; // RULE7
                end
                crc_r <= efc_crc_nib(crc_r, nib_in);
                sym_r <= sym_r | er_in;
            end
        end
    end

    // ****************************************************************
    // Frame end report
    // ****************************************************************
    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            done_out <= 1'b0;
            crc_bad_out <= 1'b0;
            sym_bad_out <= 1'b0;
            len_out <= '0;
        end else begin
            done_out <= stb_in && !dv_in && (state_r == EFC_BODY);
            if (stb_in && !dv_in && state_r == EFC_BODY) begin
                crc_bad_out <= crc_r != EFC_CRC_RESIDUE;
                sym_bad_out <= sym_r;
                len_out <= nib_cnt_r[LEN_W:1]; // RULE7
            end
        end
    end

endmodule
`default_nettype wire

// ### sim/efc_mac_model.sv
// Nibble frame source standing in for the MAC or the remote end
`timescale 1ns/100ps
`default_nettype none
module efc_mac_model
    import efc_pkg::*;
(
    input wire logic sys_clk_in,
    output logic stb_out,
    output logic dv_out,
    output logic er_out,
    output logic [3:0] nib_out
);
    initial begin
        stb_out = 1'b0;
        dv_out = 1'b0;
        er_out = 1'b0;
        nib_out = 4'h0;
    end
    // One strobed nibble; the data lines flip once the strobe drops
    task automatic put(input logic dv, input logic er, input logic [3:0] n, input int gap);
        @(posedge sys_clk_in);
        #1;
        stb_out = 1'b1;
        dv_out = dv;
        er_out = er;
        nib_out = n;
        @(posedge sys_clk_in);
        #1;
        stb_out = 1'b0;
        er_out = ~er;
        nib_out = ~n;
        repeat (gap) @(posedge sys_clk_in);
    endtask
    // Preamble, delimiter, counting bytes, FCS low byte first, then one idle strobe
    task automatic send(input int nbytes, input logic bad, input int er_at, input int gap);
        logic [31:0] crc;
        logic [7:0] b;
        crc = EFC_CRC_INIT;
        for (int i = 0; i < 15; i++) begin
            put(1'b1, 1'b0, 4'h5, gap);
        end
        put(1'b1, 1'b0, EFC_SFD_NIBBLE, gap);
        for (int i = 0; i < nbytes; i++) begin
            if (i < nbytes - 4) begin
                b = i[7:0];
                for (int k = 0; k < 8; k++) begin
                    crc = (crc >> 1) ^ (((crc[0] ^ b[k]) == 1'b1) ? EFC_CRC_POLY : 32'h00000000);
                end
            end else begin
                b = ~crc[8 * (i - nbytes + 4) +: 8] ^ {7'h00, bad && (i == nbytes - 1)};
            end
            put(1'b1, i == er_at, b[3:0], gap);
            put(1'b1, 1'b0, b[7:4], gap);
        end
        put(1'b0, 1'b0, 4'h0, gap);
    endtask
endmodule
`default_nettype wire

// ### sim/efc_frame_checker_test.sv
// Self-checking bench of the frame checker fed by two frame sources
`timescale 1ns/100ps
`default_nettype none
module efc_frame_checker_test
    import efc_pkg::*;
;
    logic clk, rst, wr, rd, rvalid, irq;
    logic [15:0] addr, wdata, rdata, e_crc, e_sym, e_osz, e_usz;
    logic [31:0] e_frm;
    logic rx_stb, rx_dv, rx_er, tx_stb, tx_en, tx_er;
    logic [3:0] rx_nib, tx_nib;
    int n_fail = 0;
    int checks_done = 0;
    efc_frame_checker efc_frame_checker_inst (.sys_clk_in(clk), .rst_in(rst), .rx_stb_in(rx_stb),
        .rx_dv_in(rx_dv), .rx_er_in(rx_er), .rx_nib_in(rx_nib), .tx_stb_in(tx_stb), .tx_en_in(tx_en),
        .tx_er_in(tx_er), .tx_nib_in(tx_nib), .reg_addr_in(addr), .reg_wdata_in(wdata), .reg_wr_in(wr),
        .reg_rd_in(rd), .reg_rdata_out(rdata), .reg_rvalid_out(rvalid), .irq_out(irq));
    efc_mac_model rx_model (.sys_clk_in(clk), .stb_out(rx_stb), .dv_out(rx_dv), .er_out(rx_er), .nib_out(rx_nib));
    efc_mac_model tx_model (.sys_clk_in(clk), .stb_out(tx_stb), .dv_out(tx_en), .er_out(tx_er), .nib_out(tx_nib));
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    task automatic complete_run();
        if (n_fail == 0 && checks_done > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [15:0] s, input logic [15:0] e);
        checks_done++;
        if (s !== e) begin
            n_fail++;
            $display("Error %s expected %h seen %h", nm, e, s);
        end
    endtask
    task automatic wrr(input logic [15:0] a, input logic [15:0] d);
        @(posedge clk);
        #1;
        addr = a;
        wdata = d;
        wr = 1'b1;
        @(posedge clk);
        #1;
        wr = 1'b0;
    endtask
    task automatic rc(input logic [15:0] a, input logic [15:0] e);
        logic ok;
        ok = 1'b0;
        @(posedge clk);
        #1;
        addr = a;
        rd = 1'b1;
        for (int i = 0; i < 4 && !ok; i++) begin
            @(posedge clk);
            #1;
            rd = 1'b0;
            if (rvalid === 1'b1) begin
                ok = 1'b1;
                chk($sformatf("reg %h", a), rdata, e);
            end
        end
        if (!ok) begin
            n_fail++;
            complete_run();
        end
    endtask
    task automatic frm(input int n, input logic bad, input int er_at, input logic tx, input int gap);
        if (tx) tx_model.send(n, bad, er_at, gap);
        else rx_model.send(n, bad, er_at, gap);
        repeat (4) @(posedge clk);
        #1;
    endtask
    task automatic check_all();
        rc(EFC_ADDR_RECEIVE_ERROR_COUNTER, e_crc);
        rc(EFC_ADDR_CNT_UPPER, e_frm[31:16]);
        rc(EFC_ADDR_CNT_LOWER, e_frm[15:0]);
        rc(EFC_ADDR_SYM_CNT, e_sym);
        rc(EFC_ADDR_OSZ_CNT, e_osz);
        rc(EFC_ADDR_USZ_CNT, e_usz);
    endtask
    task automatic do_reset();
        rst = 1'b1;
        repeat (20) @(posedge clk);
        #1;
        rst = 1'b0;
        {e_frm, e_crc, e_sym, e_osz, e_usz} = '0;
    endtask
    initial begin
        repeat (90000) @(posedge clk);
        n_fail++;
        complete_run();
    end
    initial begin
        {wr, rd, addr, wdata} = '0;
        do_reset();
        rc(EFC_ADDR_CHECKER_ON, 16'h0001);
        rc(EFC_ADDR_IRQ_ON, 16'h0001);
        rc(EFC_ADDR_SOURCE_SEL, 16'h0000);
        rc(EFC_ADDR_MAX_LEN, 16'h05F2);
        rc(EFC_ADDR_IRQ_MASK, 16'h0000);
        rc(16'h1234, 16'h0000);
        check_all();
        frm(64, 1'b0, -1, 1'b0, 0);
        frm(63, 1'b0, -1, 1'b0, 0);
        rc(EFC_ADDR_CNT_LOWER, 16'h0000);
        e_frm = 2;
        e_usz = 1;
        check_all();
        wrr(EFC_ADDR_MAX_LEN, 16'h0050);
        rc(EFC_ADDR_MAX_LEN, 16'h0050);
        frm(80, 1'b0, -1, 1'b0, 0);
        frm(81, 1'b0, -1, 1'b0, 0);
        e_frm = 4;
        e_osz = 1;
        check_all();
        frm(64, 1'b1, -1, 1'b0, 0);
        chk("irq", {15'h0000, irq}, 16'h0000);
        rc(EFC_ADDR_IRQ_STATUS, 16'h0002);
        rc(EFC_ADDR_IRQ_STATUS, 16'h0000);
        wrr(EFC_ADDR_IRQ_MASK, 16'h0002);
        rc(EFC_ADDR_IRQ_MASK, 16'h0002);
        frm(64, 1'b1, -1, 1'b0, 1);
        chk("irq", {15'h0000, irq}, 16'h0001);
        rc(EFC_ADDR_IRQ_STATUS, 16'h0002);
        @(posedge clk);
        #1;
        chk("irq", {15'h0000, irq}, 16'h0000);
        frm(70, 1'b0, 5, 1'b0, 0);
        rc(EFC_ADDR_IRQ_STATUS, 16'h0002);
        wrr(EFC_ADDR_IRQ_ON, 16'h0000);
        rc(EFC_ADDR_IRQ_ON, 16'h0000);
        frm(64, 1'b1, -1, 1'b0, 0);
        chk("irq", {15'h0000, irq}, 16'h0000);
        rc(EFC_ADDR_IRQ_STATUS, 16'h0000);
        wrr(EFC_ADDR_IRQ_ON, 16'h0001);
        wrr(EFC_ADDR_CHECKER_ON, 16'h0000);
        rc(EFC_ADDR_CHECKER_ON, 16'h0000);
        frm(64, 1'b1, -1, 1'b0, 0);
        rc(EFC_ADDR_IRQ_STATUS, 16'h0000);
        wrr(EFC_ADDR_CHECKER_ON, 16'h0001);
        wrr(EFC_ADDR_SOURCE_SEL, 16'h0001);
        rc(EFC_ADDR_SOURCE_SEL, 16'h0001);
        frm(64, 1'b0, -1, 1'b0, 0);
        frm(64, 1'b0, -1, 1'b1, 0);
        e_frm = 9;
        e_crc = 3;
        e_sym = 1;
        check_all();
        do_reset();
        rc(EFC_ADDR_MAX_LEN, 16'h05F2);
        check_all();
        complete_run();
    end
endmodule
`default_nettype wire
